// *** hw/reset_seq_pkg.sv ***
// constants, types and register layout of the system reset sequencer
// Contract
// - Trap conflict reset sets bit 15 of reset cause register, else it stays 0.
// - Illegal opcode, address mode or uninitialised pointer reset sets bit 14.
// - Bits 13 to 10 are unimplemented and read as zero.
// - Configuration mismatch reset sets bit 9.
// - Bit 8 keeps regulator active in sleep when 1; zero after power-on.
// - External reset pin reset sets bit 7.
// - Reset instruction sets bit 6.
// - Bit 5 enables watchdog; fuse at 1 keeps watchdog enabled regardless.
// - Watchdog time-out sets bit 4.
// - Entering sleep sets bit 3.
// - Entering idle sets bit 2.
// - Brownout sets bit 1, 1 after power-on; hold reset through 100 us extension.
// - Power-on sets bit 0; hold reset through 30 us extension after threshold.
// - Software may set or clear every flag; setting one causes no reset.
// - Power-on and brownout are cold resets; clock then comes from fuse selection.
// - Other resets are warm; clock stays the current clock selection.
// - Stay in reset until supplies stable and clock ready; no earlier execution. Code drops master_reset after the power-up timer, before clock ready.
// - Clock-ready delay per mode: startup, start-up timer, lock time as listed.
// - Start-up timer counts 1024 oscillator periods; lock time nominal 1.5 ms.
// - After brownout, power-up timer holds reset for programmed 0 to 128 ms.
// - Once clock ready, fetch starts at address 0x000000.
// - Clock monitor starts after clock ready plus at most 900 us.
// - Power-on clears all status flags except the power-on and brownout flags.
// - Reset instruction asserts reset one cycle, keeps clock, then fetches vector.
// - Watchdog flag cleared by power save, watchdog clear, power-on, brownout.
package reset_seq_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 10;
  localparam int POR_EXT_NS        = 30000;
  localparam int POR_EXT_CYCLES    = POR_EXT_NS / CLK_PERIOD_NS;
  localparam int BOR_EXT_NS        = 100000;
  localparam int BOR_EXT_CYCLES    = BOR_EXT_NS / CLK_PERIOD_NS;
  localparam int POWER_UP_TIMER_UNIT_NS      = 1000000;
  localparam int POWER_UP_TIMER_UNIT_CYCLES  = POWER_UP_TIMER_UNIT_NS / CLK_PERIOD_NS;
  localparam int LOCK_NS           = 1500000;
  localparam int LOCK_CYCLES       = LOCK_NS / CLK_PERIOD_NS;
  localparam int FAIL_SAFE_CLOCK_MONITOR_NS           = 900000;
  localparam int FAIL_SAFE_CLOCK_MONITOR_CYCLES       = FAIL_SAFE_CLOCK_MONITOR_NS / CLK_PERIOD_NS;
  localparam int OSCD_FAST_NS      = 1100;
  localparam int OSCD_FAST_CYCLES  = OSCD_FAST_NS / CLK_PERIOD_NS;
  localparam int OSCD_SLOW_NS      = 70000;
  localparam int OSCD_SLOW_CYCLES  = OSCD_SLOW_NS / CLK_PERIOD_NS;
  localparam logic [10:0] OST_PERIODS = 11'h400;
  localparam logic [7:0] POWER_UP_TIMER_MS_TABLE [8] = '{8'h00, 8'h02, 8'h04, 8'h08,
                                               8'h10, 8'h20, 8'h40, 8'h80};

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [1:0]  ADDR_RESET_CAUSE  = 2'h0;
  localparam logic [1:0]  ADDR_SEQ_STATUS   = 2'h1;
  localparam logic [15:0] CAUSE_WRITE_MASK  = 16'hC3FF;
  localparam logic [15:0] CAUSE_POR_VALUE   = 16'h0003;
  localparam logic [15:0] CAUSE_BOR_CLEAR   = 16'hC258;
  localparam int BIT_TRAP     = 15;
  localparam int BIT_ILLEGAL  = 14;
  localparam int BIT_CONFIG   = 9;
  localparam int BIT_REG_SLP  = 8;
  localparam int BIT_PIN      = 7;
  localparam int BIT_SOFT     = 6;
  localparam int BIT_WDT_EN   = 5;
  localparam int BIT_WDT_TO   = 4;
  localparam int BIT_SLEEP    = 3;
  localparam int BIT_IDLE     = 2;
  localparam int BIT_BOR      = 1;
  localparam int BIT_POR      = 0;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;

  // ****************************************************************
  // clock selections
  // ****************************************************************
  localparam logic [2:0] SEL_FAST_RC     = 3'h0;
  localparam logic [2:0] SEL_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SEL_PRIMARY     = 3'h2;
  localparam logic [2:0] SEL_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SEL_SECONDARY   = 3'h4;
  localparam logic [2:0] SEL_LOW_POWER   = 3'h5;

  typedef enum logic [2:0] {
    ST_POR_EXT, ST_BOR_EXT, ST_POWER_UP_TIMER, ST_OSCD, ST_OST, ST_LOCK, ST_RUN, ST_WARM
  } seq_state_t;

endpackage

// *** hw/input_filter.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module input_filter #(
  parameter int         WIDTH     = 4,
  parameter logic [3:0] RESET_VAL = 4'h0
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] filtered
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } filter_regs_t;

  filter_regs_t s;
  filter_regs_t next_s;

  always_comb begin
    next_s        = s;
    next_s.stage1 = pin_in;
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2;
    next_s.level  = (~(s.stage2 ^ s.stage3) & s.stage3) | ((s.stage2 ^ s.stage3) & s.level);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= {4{RESET_VAL[WIDTH-1:0]}};
    end else begin
      s <= next_s;
    end
  end

  assign filtered = s.level;

endmodule

// *** hw/system_reset_sequencer.sv ***
// system reset sequencer: reset merge, cold and warm sequences, reset cause register
`timescale 1ns/1ns
module system_reset_sequencer #(
  parameter int unsigned BOR_EXT_CYCLES   = reset_seq_pkg::BOR_EXT_CYCLES,
  parameter int unsigned POWER_UP_TIMER_UNIT_CYCLES = reset_seq_pkg::POWER_UP_TIMER_UNIT_CYCLES,
  parameter int unsigned LOCK_CYCLES      = reset_seq_pkg::LOCK_CYCLES,
  parameter int unsigned FAIL_SAFE_CLOCK_MONITOR_CYCLES      = reset_seq_pkg::FAIL_SAFE_CLOCK_MONITOR_CYCLES,
  parameter int unsigned OSCD_SLOW_CYCLES = reset_seq_pkg::OSCD_SLOW_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        power_on_ok,
  input  wire logic        brownout_ok,
  input  wire logic        external_reset_pin_n,
  input  wire logic        osc_clk_in,
  input  wire logic        trap_conflict,
  input  wire logic        illegal_condition,
  input  wire logic        config_mismatch,
  input  wire logic        soft_reset_exec,
  input  wire logic        watchdog_timeout,
  input  wire logic        cpu_power_saving,
  input  wire logic        sleep_entered,
  input  wire logic        idle_entered,
  input  wire logic        power_save_exec,
  input  wire logic        watchdog_clear,
  input  wire logic        watchdog_fuse_enable,
  input  wire logic [2:0]  initial_clock_select,
  input  wire logic        primary_is_external,
  input  wire logic [2:0]  power_up_delay_select,
  input  wire logic        fail_safe_enable,
  input  wire logic        clock_switch_done,
  input  wire logic [2:0]  clock_switch_select,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [15:0]      reg_rdata,
  output logic             master_reset,
  output logic             fetch_enable,
  output logic             fetch_start,
  output logic [23:0]      fetch_address,
  output logic [2:0]       current_clock_select,
  output logic             clock_monitor_enable,
  output logic             watchdog_enable,
  output logic             regulator_sleep_active
);
  import reset_seq_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    seq_state_t  state;
    logic [23:0] cnt;
    logic [10:0] ost_cnt;
    logic        osc_prev;
    logic [15:0] cause;
    logic [2:0]  clock_source;
    logic        master_reset;
    logic        fetch_enable;
    logic        fetch_start;
    logic [23:0] fetch_address;
    logic        monitor_enable;
    logic        watchdog_enable;
    logic [15:0] rd_data;
  } seq_regs_t;

  localparam seq_regs_t SEQ_RESET = '{
    state:           ST_POR_EXT,
    cnt:             24'h000000,
    ost_cnt:         11'h000,
    osc_prev:        1'b0,
    cause:           CAUSE_POR_VALUE,
    clock_source:    SEL_FAST_RC,
    master_reset:    1'b1,
    fetch_enable:    1'b0,
    fetch_start:     1'b0,
    fetch_address:   RESET_VECTOR,
    monitor_enable:  1'b0,
    watchdog_enable: 1'b1,
    rd_data:         16'h0000
  };

  seq_regs_t  s;
  seq_regs_t  next_s;
  logic [3:0] pins;
  logic       supply_por_ok;
  logic       supply_bor_ok;
  logic       pin_reset_n;
  logic       osc_level;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  input_filter #(
    .WIDTH     (4),
    .RESET_VAL (4'h4)
  ) u_pins (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .pin_in   ({osc_clk_in, external_reset_pin_n, brownout_ok, power_on_ok}),
    .filtered (pins)
  );

  assign supply_por_ok = pins[0];
  assign supply_bor_ok = pins[1];
  assign pin_reset_n   = pins[2];
  assign osc_level     = pins[3];

  // ****************************************************************
  // decoding
  // ****************************************************************
  // returns {needs startup delay, needs start-up timer, needs lock}
  function automatic logic [2:0] clock_ready_needs(input logic [2:0] sel,
                                                   input logic       ext);
    logic [2:0] r;
    r = 3'h4;
    case (sel)
      SEL_FAST_RC_PLL: r = 3'h5;
      SEL_PRIMARY:     r = ext ? 3'h0 : 3'h6;
      SEL_PRIMARY_PLL: r = ext ? 3'h1 : 3'h7;
      SEL_SECONDARY:   r = 3'h6;
      default:         r = 3'h4;
    endcase
    return r;
  endfunction

  function automatic logic [23:0] last_count(input int unsigned cycles);
    return (cycles == 0) ? 24'h000000 : 24'(cycles - 1);
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [2:0]  needs;
  logic [23:0] power_up_timer_target;
  logic [23:0] oscd_last;
  logic        cold_por;
  logic        cold_bor;
  logic        wdt_reset;
  logic        warm;
  logic        osc_rise;

  always_comb begin
    needs       = clock_ready_needs(s.clock_source, primary_is_external);
    power_up_timer_target = 24'(POWER_UP_TIMER_UNIT_CYCLES * int'(POWER_UP_TIMER_MS_TABLE[power_up_delay_select]));
    oscd_last   = (s.clock_source == SEL_LOW_POWER) ? last_count(OSCD_SLOW_CYCLES)
                                                    : last_count(OSCD_FAST_CYCLES);
    cold_por    = !supply_por_ok;
    cold_bor    = supply_por_ok && !supply_bor_ok;
    wdt_reset   = watchdog_timeout && !cpu_power_saving;
    warm        = !pin_reset_n || trap_conflict || illegal_condition || config_mismatch ||
                  soft_reset_exec || wdt_reset;
    osc_rise    = osc_level && !s.osc_prev;

    next_s                 = s;
    next_s.fetch_start     = 1'b0;
    next_s.osc_prev        = osc_level;
    next_s.fetch_address   = RESET_VECTOR;
    next_s.rd_data         = 16'h0000;

    // software writes; no reset follows a write
    if (reg_write && reg_addr == ADDR_RESET_CAUSE) begin
      next_s.cause = reg_wdata & CAUSE_WRITE_MASK;
    end
    if (power_save_exec || watchdog_clear) begin
      next_s.cause[BIT_WDT_TO] = 1'b0;
    end

    if (cold_por) begin
      next_s.cause          = CAUSE_POR_VALUE;
      next_s.state          = ST_POR_EXT;
      next_s.cnt            = 24'h000000;
      next_s.clock_source   = initial_clock_select;
      next_s.master_reset   = 1'b1;
      next_s.fetch_enable   = 1'b0;
      next_s.monitor_enable = 1'b0;
    end else if (cold_bor) begin
      next_s.cause          = (next_s.cause & ~CAUSE_BOR_CLEAR) | 16'h0002;
      next_s.state          = ST_BOR_EXT;
      next_s.cnt            = 24'h000000;
      next_s.clock_source   = initial_clock_select;
      next_s.master_reset   = 1'b1;
      next_s.fetch_enable   = 1'b0;
      next_s.monitor_enable = 1'b0;
    end else begin
      // hardware sets win over a software clear in the same cycle
      if (trap_conflict) begin
        next_s.cause[BIT_TRAP] = 1'b1;
      end
      if (illegal_condition) begin
        next_s.cause[BIT_ILLEGAL] = 1'b1;
      end
      if (config_mismatch) begin
        next_s.cause[BIT_CONFIG] = 1'b1;
      end
      if (!pin_reset_n) begin
        next_s.cause[BIT_PIN] = 1'b1;
      end
      if (soft_reset_exec) begin
        next_s.cause[BIT_SOFT] = 1'b1;
      end
      if (watchdog_timeout) begin
        next_s.cause[BIT_WDT_TO] = 1'b1;
      end
      if (sleep_entered) begin
        next_s.cause[BIT_SLEEP] = 1'b1;
      end
      if (idle_entered) begin
        next_s.cause[BIT_IDLE] = 1'b1;
      end
      if (clock_switch_done) begin
        next_s.clock_source = clock_switch_select;
      end

      if (warm && (s.state == ST_RUN || s.state == ST_WARM)) begin
        // warm reset keeps the running clock source
        next_s.state        = ST_WARM;
        next_s.master_reset = 1'b1;
        next_s.fetch_enable = 1'b0;
      end else begin
        case (s.state)
          ST_POR_EXT: begin
            next_s.cnt = s.cnt + 24'h000001;
            if (s.cnt >= last_count(POR_EXT_CYCLES)) begin
              next_s.state = ST_BOR_EXT;
              next_s.cnt   = 24'h000000;
            end
          end
          ST_BOR_EXT: begin
            next_s.cnt = s.cnt + 24'h000001;
            if (s.cnt >= last_count(BOR_EXT_CYCLES)) begin
              next_s.state = ST_POWER_UP_TIMER;
              next_s.cnt   = 24'h000000;
            end
          end
          ST_POWER_UP_TIMER: begin
            next_s.cnt = s.cnt + 24'h000001;
            if (s.cnt >= power_up_timer_target) begin
              next_s.state        = ST_OSCD;
              next_s.cnt          = 24'h000000;
              next_s.master_reset = 1'b0;
            end
          end
          ST_OSCD: begin
            next_s.cnt = s.cnt + 24'h000001;
            if (!needs[2] || s.cnt >= oscd_last) begin
              next_s.state   = ST_OST;
              next_s.cnt     = 24'h000000;
              next_s.ost_cnt = 11'h000;
            end
          end
          ST_OST: begin
            if (osc_rise) begin
              next_s.ost_cnt = s.ost_cnt + 11'h001;
            end
            if (!needs[1] || (osc_rise && s.ost_cnt >= OST_PERIODS - 11'h001)) begin
              next_s.state = ST_LOCK;
              next_s.cnt   = 24'h000000;
            end
          end
          ST_LOCK: begin
            next_s.cnt = s.cnt + 24'h000001;
            if (!needs[0] || s.cnt >= last_count(LOCK_CYCLES)) begin
              next_s.state        = ST_RUN;
              next_s.cnt          = 24'h000000;
              next_s.fetch_enable = 1'b1;
              next_s.fetch_start  = 1'b1;
            end
          end
          ST_RUN: begin
            if (fail_safe_enable && !s.monitor_enable) begin
              next_s.cnt = s.cnt + 24'h000001;
              if (s.cnt >= last_count(FAIL_SAFE_CLOCK_MONITOR_CYCLES)) begin
                next_s.monitor_enable = 1'b1;
              end
            end
          end
          ST_WARM: begin
            next_s.state        = ST_RUN;
            next_s.master_reset = 1'b0;
            next_s.fetch_enable = 1'b1;
            next_s.fetch_start  = 1'b1;
          end
          default: begin
            next_s.state = ST_POR_EXT;
            next_s.cnt   = 24'h000000;
          end
        endcase
      end
    end

    next_s.watchdog_enable = watchdog_fuse_enable || next_s.cause[BIT_WDT_EN];

    // ****************************************************************
    // register read port
    // ****************************************************************
    if (reg_read) begin
      case (reg_addr)
        ADDR_RESET_CAUSE: next_s.rd_data = s.cause & CAUSE_WRITE_MASK;
        ADDR_SEQ_STATUS:  next_s.rd_data = {9'h000, s.clock_source, s.monitor_enable,
                                            s.fetch_enable, s.master_reset,
                                            1'b0};
        default:          next_s.rd_data = 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= SEQ_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata              = s.rd_data;
  assign master_reset           = s.master_reset;
  assign fetch_enable           = s.fetch_enable;
  assign fetch_start            = s.fetch_start;
  assign fetch_address          = s.fetch_address;
  assign current_clock_select   = s.clock_source;
  assign clock_monitor_enable   = s.monitor_enable;
  assign watchdog_enable        = s.watchdog_enable;
  assign regulator_sleep_active = s.cause[BIT_REG_SLP];

endmodule

// *** tb/system_reset_sequencer_props.sv ***
// concurrent checks on the ports of the system reset sequencer
`timescale 1ns/1ns
module system_reset_sequencer_props (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        power_on_ok,
  input wire logic        brownout_ok,
  input wire logic        trap_conflict,
  input wire logic        illegal_condition,
  input wire logic        config_mismatch,
  input wire logic        soft_reset_exec,
  input wire logic        watchdog_timeout,
  input wire logic        watchdog_fuse_enable,
  input wire logic        fail_safe_enable,
  input wire logic [1:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic [15:0] reg_rdata,
  input wire logic        master_reset,
  input wire logic        fetch_enable,
  input wire logic        fetch_start,
  input wire logic [23:0] fetch_address,
  input wire logic [2:0]  current_clock_select,
  input wire logic        clock_monitor_enable,
  input wire logic        watchdog_enable,
  input wire logic        regulator_sleep_active
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_RESERVED_ZERO: assert property (reg_rdata[13:10] == 4'h0)
    else $error("reserved cause bits read nonzero");
  AST_SUPPLY_HOLD: assert property (
    !(power_on_ok && brownout_ok) |-> ##[0:6] master_reset)
    else $error("supply low without master reset");
  AST_NO_EARLY_FETCH: assert property (fetch_enable |-> !master_reset)
    else $error("fetch enabled while in reset");
  AST_VECTOR: assert property (
    fetch_start |-> fetch_enable && fetch_address == 24'h000000)
    else $error("fetch start not at reset vector");
  AST_WARM_ASSERT: assert property (fetch_enable && (trap_conflict || illegal_condition
    || config_mismatch || soft_reset_exec) |=> master_reset && !fetch_enable)
    else $error("warm source did not assert reset");
  AST_SOFT_ONE_CYCLE: assert property (fetch_enable && soft_reset_exec && !trap_conflict
    && !illegal_condition && !config_mismatch && !watchdog_timeout
    |=> master_reset ##1 (!master_reset && fetch_start))
    else $error("soft reset not one cycle then vector fetch");
  AST_WARM_KEEP_CLOCK: assert property (fetch_enable && soft_reset_exec
    |=> $stable(current_clock_select))
    else $error("warm reset changed clock source");
  AST_FUSE_WDT: assert property (watchdog_fuse_enable |=> watchdog_enable)
    else $error("fuse did not force watchdog on");
  AST_REG_SLEEP: assert property (reg_write && reg_addr == 2'h0 && reg_wdata[8]
    |-> ##[1:2] regulator_sleep_active)
    else $error("regulator bit not followed");
  AST_WRITE_NO_RESET: assert property (fetch_enable && reg_write && !trap_conflict
    && !illegal_condition && !config_mismatch && !soft_reset_exec && !watchdog_timeout
    |=> !master_reset)
    else $error("register write caused reset");
  AST_MONITOR_LATE: assert property ($rose(clock_monitor_enable)
    |-> fail_safe_enable && fetch_enable)
    else $error("clock monitor started before clock ready");
endmodule

// *** tb/testbench.sv ***
// self-checking bench of the system reset sequencer
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
  import reset_seq_pkg::*;
  logic        ref_clk, reset_n, power_on_ok, brownout_ok, external_reset_pin_n;
  logic        osc_clk_in, cpu_power_saving, watchdog_fuse_enable, primary_is_external;
  logic        fail_safe_enable, reg_write, reg_read;
  logic        master_reset, fetch_enable, fetch_start;
  logic        clock_monitor_enable, watchdog_enable, regulator_sleep_active;
  logic [2:0]  initial_clock_select, power_up_delay_select, clock_switch_select;
  logic [2:0]  current_clock_select, osc_cnt;
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rdat;
  logic [23:0] fetch_address;
  logic [9:0]  pl;
  logic [15:0] flag [5] = '{16'h8000, 16'h4000, 16'h0200, 16'h0040, 16'h0010};
  int          failures, checks, n;

  system_reset_sequencer #(.BOR_EXT_CYCLES(20), .POWER_UP_TIMER_UNIT_CYCLES(10), .LOCK_CYCLES(30),
    .FAIL_SAFE_CLOCK_MONITOR_CYCLES(40), .OSCD_SLOW_CYCLES(15)) u_system_reset_sequencer (
    .ref_clk, .reset_n, .power_on_ok, .brownout_ok, .external_reset_pin_n, .osc_clk_in,
    .trap_conflict(pl[0]), .illegal_condition(pl[1]), .config_mismatch(pl[2]),
    .soft_reset_exec(pl[3]), .watchdog_timeout(pl[4]), .cpu_power_saving,
    .sleep_entered(pl[5]), .idle_entered(pl[6]), .power_save_exec(pl[7]),
    .watchdog_clear(pl[8]), .watchdog_fuse_enable, .initial_clock_select,
    .primary_is_external, .power_up_delay_select, .fail_safe_enable,
    .clock_switch_done(pl[9]), .clock_switch_select, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .master_reset, .fetch_enable, .fetch_start, .fetch_address,
    .current_clock_select, .clock_monitor_enable, .watchdog_enable, .regulator_sleep_active);

  // ****************************************************************
  // clocks and bus tasks
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // oscillator pin at a tenth of the system rate
  always @(posedge ref_clk) begin
    osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
    if (osc_cnt == 3'h4) osc_clk_in <= ~osc_clk_in;
  end

  task end_sim;
    $display("comparisons %0d mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task rd(input logic [1:0] a);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 rdat = reg_rdata;
  endtask

  task pulse(input int i);
    @(posedge ref_clk);
    pl[i] <= 1'b1;
    @(posedge ref_clk);
    pl[i] <= 1'b0;
    #1;
  endtask

  // counts cycles until execution is enabled
  task wait_run;
    n = 0;
    while (fetch_enable !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 12000) begin
        failures++;
        end_sim();
      end
    end
    `CHK(fetch_start, 1'b1)
    @(posedge ref_clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_cold;
    @(posedge ref_clk);
    power_on_ok <= 1'b1;
    brownout_ok <= 1'b1;
    wait_run();
    `CHK((n >= 3160 && n <= 3220), 1'b1)
    `CHK(current_clock_select, SEL_FAST_RC_PLL)
    `CHK(fetch_address, 24'h000000)
    rd(2'h0);
    `CHK(rdat, 16'h0003)
    repeat (30) @(posedge ref_clk);
    `CHK(clock_monitor_enable, 1'b0)
    repeat (20) @(posedge ref_clk);
    `CHK(clock_monitor_enable, 1'b1)
    $display("cold start done");
  endtask

  task t_regs;
    wr(2'h0, 16'hFFFF);
    `CHK(master_reset, 1'b0)
    rd(2'h0);
    `CHK(rdat, 16'hC3FF)
    `CHK(regulator_sleep_active, 1'b1)
    watchdog_fuse_enable <= 1'b0;
    wr(2'h0, 16'h0020);
    wr(2'h3, 16'hFFFF);
    `CHK(watchdog_enable, 1'b1)
    wr(2'h0, 16'h0000);
    @(posedge ref_clk);
    `CHK(watchdog_enable, 1'b0)
    rd(2'h3);
    `CHK(rdat, 16'h0000)
    $display("register access done");
  endtask

  task t_warm;
    pulse(9);
    for (int i = 0; i < 5; i++) begin
      wr(2'h0, 16'h0000);
      pulse(i);
      `CHK({master_reset, fetch_enable}, 2'b10)
      wait_run();
      `CHK(current_clock_select, SEL_PRIMARY)
      rd(2'h0);
      `CHK(rdat, flag[i])
    end
    wr(2'h0, 16'h0000);
    external_reset_pin_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    external_reset_pin_n <= 1'b1;
    #1 `CHK(master_reset, 1'b1)
    wait_run();
    rd(2'h0);
    `CHK(rdat, 16'h0080)
    $display("warm resets done");
  endtask

  task t_flags;
    wr(2'h0, 16'h0000);
    pulse(5);
    pulse(6);
    cpu_power_saving <= 1'b1;
    pulse(4);
    `CHK(master_reset, 1'b0)
    rd(2'h0);
    `CHK(rdat, 16'h001C)
    pulse(8);
    rd(2'h0);
    `CHK(rdat, 16'h000C)
    cpu_power_saving <= 1'b0;
    $display("status flags done");
  endtask

  task t_brownout;
    wr(2'h0, 16'h00C0);
    @(posedge ref_clk);
    brownout_ok <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK(master_reset, 1'b1)
    initial_clock_select <= SEL_SECONDARY;
    power_up_delay_select <= 3'h1;
    brownout_ok <= 1'b1;
    wait_run();
    `CHK((n >= 10380 && n <= 10440), 1'b1)
    `CHK(current_clock_select, SEL_SECONDARY)
    rd(2'h0);
    `CHK(rdat, 16'h0082)
    $display("brownout done");
  endtask

  task t_modes;
    wr(2'h0, 16'hC3FF);
    @(posedge ref_clk);
    power_on_ok <= 1'b0;
    initial_clock_select <= SEL_PRIMARY_PLL;
    primary_is_external <= 1'b1;
    repeat (8) @(posedge ref_clk);
    `CHK({master_reset, fetch_enable}, 2'b10)
    power_on_ok <= 1'b1;
    wait_run();
    `CHK((n >= 3070 && n <= 3090), 1'b1)
    `CHK(current_clock_select, SEL_PRIMARY_PLL)
    `CHK(regulator_sleep_active, 1'b0)
    rd(2'h0);
    `CHK(rdat, 16'h0003)
    @(posedge ref_clk);
    initial_clock_select <= SEL_LOW_POWER;
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_run();
    `CHK((n >= 3055 && n <= 3075), 1'b1)
    `CHK(current_clock_select, SEL_LOW_POWER)
    $display("clock modes done");
  endtask

  initial begin
    {reset_n, power_on_ok, brownout_ok, osc_clk_in, cpu_power_saving} = 5'h00;
    {reg_write, reg_read, primary_is_external, pl, osc_cnt} = 16'h0000;
    {external_reset_pin_n, watchdog_fuse_enable, fail_safe_enable} = 3'h7;
    initial_clock_select = SEL_FAST_RC_PLL;
    power_up_delay_select = 3'h0;
    clock_switch_select = SEL_PRIMARY;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    failures = 0;
    checks = 0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_cold();
    t_regs();
    t_warm();
    t_flags();
    t_brownout();
    t_modes();
    end_sim();
  end
endmodule

bind system_reset_sequencer system_reset_sequencer_props u_props (.ref_clk, .reset_n,
  .power_on_ok, .brownout_ok, .trap_conflict, .illegal_condition, .config_mismatch,
  .soft_reset_exec, .watchdog_timeout, .watchdog_fuse_enable, .fail_safe_enable, .reg_addr,
  .reg_wdata, .reg_write, .reg_rdata, .master_reset, .fetch_enable, .fetch_start,
  .fetch_address, .current_clock_select, .clock_monitor_enable, .watchdog_enable,
  .regulator_sleep_active);
